// [design/agicr_pkg.sv]
// constants, field layout and bus carrier for the pin, id and channel register bank
package agicr_pkg;
  localparam int AGICR_ADDR_W = 8;
  localparam int AGICR_DATA_W = 16;
  localparam int AGICR_NUM_CH = 16;
  // register offsets
  localparam logic [7:0] AGICR_GPCFG_ADDR = 8'h06;
  localparam logic [7:0] AGICR_ID_ADDR = 8'h07;
  localparam logic [7:0] AGICR_CH_BASE = 8'h10;
  localparam logic [7:0] AGICR_CH_LAST = 8'h1f;
  // pin configuration fields
  localparam int AGICR_PIN1_IN_EN_BIT = 5;
  localparam int AGICR_PIN0_IN_EN_BIT = 4;
  localparam int AGICR_PIN1_OUT_EN_BIT = 3;
  localparam int AGICR_PIN0_OUT_EN_BIT = 2;
  localparam int AGICR_PIN1_VAL_BIT = 1;
  localparam int AGICR_PIN0_VAL_BIT = 0;
  localparam logic [5:0] AGICR_GPCFG_RST = 6'h00;
  // channel register fields
  localparam int AGICR_CH_EN_BIT = 15;
  localparam int AGICR_SETUP_HI = 14;
  localparam int AGICR_SETUP_LO = 12;
  localparam int AGICR_INPUT_HI = 9;
  localparam int AGICR_INPUT_LO = 0;
  localparam logic [15:0] AGICR_CH0_RST = 16'h8001;
  localparam logic [15:0] AGICR_CHN_RST = 16'h0001;
  localparam logic [15:0] AGICR_CH_WMASK = 16'hf3ff;
  // sequencer and pin driver resets
  localparam logic [3:0] AGICR_SEQ_RST_CH = 4'h0;
  localparam logic [1:0] AGICR_OE_N_RST = 2'b11;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AGICR_ADDR_W-1:0] addr;
    logic [AGICR_DATA_W-1:0] wdata;
  } agicr_bus_req_type;
endpackage

// [design/agicr_regs.sv]
// register bank: general pin control, product code, channel table and channel sequencer
//
// What this block does
// RL1: bit 5 makes pin one an input
// RL2: bit 4 makes pin zero an input
// RL3: bit 3 drives pin one as output
// RL4: bit 2 drives pin zero as output
// RL5: bits 1,0 write drive, read pin levels on input pins
// RL6: read-only 16-bit product code at 0x07
// RL7: sixteen channel registers at 0x10 to 0x1f
// RL8: channel zero resets to 0x8001, others disabled
// RL9: bit 15 enables; enabled channels sequence automatically
// RL10: bits 14:12 pick one of eight setups
// RL11: chosen setup applies its four registers together
// RL12: host writes equal selectors to share setup
// RL13: bits 9:0 choose the input pair code
// RL14: bits 11,10 read zero, ignore writes
`timescale 1ns/10ps
`default_nettype none

module agicr_regs
  import agicr_pkg::*;
#(
  // arbitrary neutral product code
  parameter logic [15:0] ID_CODE = 16'h5a01
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire agicr_bus_req_type bus_req,
  output logic [AGICR_DATA_W-1:0] rdata,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe_n,
  input wire logic conv_done,
  output logic seq_active,
  output logic [3:0] active_channel,
  output logic [2:0] active_setup,
  output logic [9:0] active_input_code
);

  // pin configuration: enables and data
  logic [5:0] gp_cfg;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [AGICR_DATA_W-1:0] ch_cfg [AGICR_NUM_CH];
  logic [AGICR_NUM_CH-1:0] ch_en;
  logic [AGICR_DATA_W-1:0] next_rdata;
  logic [3:0] next_channel;

  wire hit_gp = bus_req.addr == AGICR_GPCFG_ADDR;
  wire hit_id = bus_req.addr == AGICR_ID_ADDR;
  wire hit_ch = (bus_req.addr >= AGICR_CH_BASE) && (bus_req.addr <= AGICR_CH_LAST); // [RL7]
  wire [3:0] ch_idx = 4'(bus_req.addr - AGICR_CH_BASE);
  wire wr_gp = bus_req.wr && hit_gp;
  wire wr_ch = bus_req.wr && hit_ch;

  wire [1:0] in_en = {gp_cfg[AGICR_PIN1_IN_EN_BIT], gp_cfg[AGICR_PIN0_IN_EN_BIT]};
  wire [1:0] out_en = {gp_cfg[AGICR_PIN1_OUT_EN_BIT], gp_cfg[AGICR_PIN0_OUT_EN_BIT]};
  wire [1:0] gp_val = {gp_cfg[AGICR_PIN1_VAL_BIT], gp_cfg[AGICR_PIN0_VAL_BIT]};
  // an input pin reads back its level; otherwise the stored drive value
  wire [1:0] gp_readback = (in_en & pin_sync) | (~in_en & gp_val); // [RL5] [RL1] [RL2]
  wire [15:0] gp_word = {10'h000, gp_cfg[5:2], gp_readback};

  // pin configuration register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gp_cfg <= AGICR_GPCFG_RST;
    end else if (wr_gp) begin
      gp_cfg <= bus_req.wdata[5:0]; // [RL1] [RL2] [RL3] [RL4] [RL5]
    end
  end

  // pins come from outside the clock domain, two flops before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 2'b00;
      pin_sync <= 2'b00;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // pin drivers; enable is active low while driving
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 2'b00;
      pin_oe_n <= AGICR_OE_N_RST;
    end else begin
      pin_out <= gp_val; // [RL5]
      pin_oe_n <= ~out_en; // [RL3] [RL4]
    end
  end

  // channel table; reserved bits never store
  for (genvar i = 0; i < AGICR_NUM_CH; i++) begin : g_ch
    localparam logic [15:0] RST_VAL = (i == 0) ? AGICR_CH0_RST : AGICR_CHN_RST;
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ch_cfg[i] <= RST_VAL; // [RL8]
      end else if (wr_ch && (ch_idx == 4'(i))) begin
        ch_cfg[i] <= bus_req.wdata & AGICR_CH_WMASK; // [RL14] [RL10] [RL13]
      end
    end
    assign ch_en[i] = ch_cfg[i][AGICR_CH_EN_BIT]; // [RL9]
  end

  // read mux; unmapped addresses and the id on write are harmless
  always_comb begin
    next_rdata = 16'h0000;
    if (!bus_req.rd) begin
      next_rdata = 16'h0000;
    end else if (hit_gp) begin
      next_rdata = gp_word;
    end else if (hit_id) begin
      next_rdata = ID_CODE; // [RL6]
    end else if (hit_ch) begin
      next_rdata = ch_cfg[ch_idx];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // next enabled channel after cur, wrapping; cur itself if it is the only one
  function automatic logic [3:0] agicr_next_ch(input logic [3:0] cur,
                                               input logic [15:0] en);
    logic [3:0] idx;
    logic [3:0] pick;
    logic found;
    pick = cur;
    found = 1'b0;
    for (int k = 1; k <= 16; k++) begin
      idx = cur + 4'(k);
      if (!found && en[idx]) begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // advance on each finished conversion, or at once if the current one was disabled
  wire seq_advance = conv_done || !ch_en[active_channel];
  assign next_channel = seq_advance ? agicr_next_ch(active_channel, ch_en) : active_channel;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_channel <= AGICR_SEQ_RST_CH;
      seq_active <= 1'b0;
    end else begin
      active_channel <= next_channel; // [RL9]
      seq_active <= |ch_en;
    end
  end

  // the setup index selects the setup, filter, offset and gain group as one;
  // registered, so it trails the channel by one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_setup <= 3'h0;
      active_input_code <= 10'h000;
    end else begin
      active_setup <= ch_cfg[active_channel][AGICR_SETUP_HI:AGICR_SETUP_LO]; // [RL10] [RL11]
      active_input_code <= ch_cfg[active_channel][AGICR_INPUT_HI:AGICR_INPUT_LO]; // [RL13]
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_ID_READ: assert property ( // [RL6]
    bus_req.rd && hit_id |=> rdata == ID_CODE
  ) else $error("product code read wrong");

  AST_ID_WRITE_IGNORED: assert property ( // [RL6]
    bus_req.wr && hit_id ##1 bus_req.rd && hit_id |=> rdata == ID_CODE
  ) else $error("product code changed by a write");

  AST_CH_RESERVED_ZERO: assert property ( // [RL14]
    bus_req.rd && hit_ch |=> rdata[11:10] == 2'b00
  ) else $error("reserved channel bits not zero");

  AST_CH_WRITE_READ: assert property ( // [RL7]
    wr_ch ##1 bus_req.rd && (bus_req.addr == $past(bus_req.addr)) && !bus_req.wr
      |=> rdata == ($past(bus_req.wdata, 2) & AGICR_CH_WMASK)
  ) else $error("channel register did not keep written value");

  AST_PIN1_OUTPUT: assert property ( // [RL3]
    wr_gp |-> ##2 pin_oe_n[1] == !$past(bus_req.wdata[AGICR_PIN1_OUT_EN_BIT], 2)
  ) else $error("pin one drive enable wrong");

  AST_PIN0_OUTPUT: assert property ( // [RL4]
    wr_gp |-> ##2 pin_oe_n[0] == !$past(bus_req.wdata[AGICR_PIN0_OUT_EN_BIT], 2)
  ) else $error("pin zero drive enable wrong");

  AST_PIN_DRIVE_VALUE: assert property ( // [RL5]
    wr_gp ##1 !wr_gp |=> pin_out == $past(bus_req.wdata[1:0], 2)
  ) else $error("pin drive value wrong");

  AST_PIN1_READBACK: assert property ( // [RL1]
    bus_req.rd && hit_gp && in_en[1] |=> rdata[1] == $past(pin_sync[1])
  ) else $error("pin one readback not the pin level");

  AST_PIN0_READBACK: assert property ( // [RL2]
    bus_req.rd && hit_gp && in_en[0] |=> rdata[0] == $past(pin_sync[0])
  ) else $error("pin zero readback not the pin level");

  AST_SEQ_ON_ENABLED: assert property ( // [RL9]
    conv_done && (|ch_en) ##1 !wr_ch [*2] |-> ch_en[active_channel]
  ) else $error("sequencer sits on a disabled channel");

  AST_SEQ_ADVANCES: assert property ( // [RL9]
    conv_done && !wr_ch && ch_en[active_channel] && ($countones(ch_en) > 1)
      |=> active_channel != $past(active_channel)
  ) else $error("sequencer did not move on");

  AST_SETUP_FOLLOWS: assert property ( // [RL10]
    !wr_ch && $stable(active_channel)
      |=> active_setup == ch_cfg[$past(active_channel)][AGICR_SETUP_HI:AGICR_SETUP_LO]
  ) else $error("active setup does not match channel");

  AST_INPUT_FOLLOWS: assert property ( // [RL13]
    !wr_ch |=> active_input_code == $past(ch_cfg[active_channel][9:0])
  ) else $error("active input code does not match channel");

  // register bus read side: every field reads back what the bank holds, except bits 1,0 of an input pin, which read its level

  AST_GP_UPPER_ZERO: assert property ( // [RL5]
    bus_req.rd && hit_gp
      |=> rdata[15:6] == 10'h000
  ) else $error("pin config upper bits not zero");

  AST_UNMAPPED_ZERO: assert property ( // [RL7]
    bus_req.rd && !hit_gp && !hit_id && !hit_ch
      |=> rdata == 16'h0000
  ) else $error("unmapped read not zero");

  AST_RDATA_IDLE: assert property ( // [RL7]
    !bus_req.rd
      |=> rdata == 16'h0000
  ) else $error("read data stands without a read");

  AST_PIN1_IN_CFG_READ: assert property ( // [RL1]
    bus_req.rd && hit_gp
      |=> rdata[AGICR_PIN1_IN_EN_BIT] == $past(gp_cfg[AGICR_PIN1_IN_EN_BIT])
  ) else $error("pin one input enable reads wrong");

  AST_PIN0_IN_CFG_READ: assert property ( // [RL2]
    bus_req.rd && hit_gp
      |=> rdata[AGICR_PIN0_IN_EN_BIT] == $past(gp_cfg[AGICR_PIN0_IN_EN_BIT])
  ) else $error("pin zero input enable reads wrong");

  AST_PIN1_OUT_CFG_READ: assert property ( // [RL3]
    bus_req.rd && hit_gp
      |=> rdata[AGICR_PIN1_OUT_EN_BIT] == $past(gp_cfg[AGICR_PIN1_OUT_EN_BIT])
  ) else $error("pin one output enable reads wrong");

  AST_PIN0_OUT_CFG_READ: assert property ( // [RL4]
    bus_req.rd && hit_gp
      |=> rdata[AGICR_PIN0_OUT_EN_BIT] == $past(gp_cfg[AGICR_PIN0_OUT_EN_BIT])
  ) else $error("pin zero output enable reads wrong");

  AST_PIN1_STORED_READ: assert property ( // [RL5]
    bus_req.rd && hit_gp && !in_en[1]
      |=> rdata[1] == $past(gp_val[1])
  ) else $error("pin one stored value reads wrong");

  AST_PIN0_STORED_READ: assert property ( // [RL5]
    bus_req.rd && hit_gp && !in_en[0]
      |=> rdata[0] == $past(gp_val[0])
  ) else $error("pin zero stored value reads wrong");

  AST_CH_READ: assert property ( // [RL7]
    bus_req.rd && hit_ch
      |=> rdata == $past(ch_cfg[ch_idx])
  ) else $error("channel read data wrong");

  AST_CH_EN_READ: assert property ( // [RL9]
    bus_req.rd && hit_ch
      |=> rdata[AGICR_CH_EN_BIT] == $past(ch_en[ch_idx])
  ) else $error("channel enable reads wrong");

  AST_CH_SETUP_READ: assert property ( // [RL10]
    bus_req.rd && hit_ch
      |=> rdata[14:12] == $past(ch_cfg[ch_idx][14:12])
  ) else $error("setup selector reads wrong");

  // storage: writes land whole but for the reserved channel bits, nothing else moves

  AST_GP_WRITE: assert property ( // [RL5]
    wr_gp
      |=> gp_cfg == $past(bus_req.wdata[5:0])
  ) else $error("pin config write lost");

  AST_GP_HOLDS: assert property ( // [RL1]
    !wr_gp
      |=> gp_cfg == $past(gp_cfg)
  ) else $error("pin config changed without a write");

  AST_CH_WRITE_TAKES: assert property ( // [RL7]
    wr_ch
      |=> ch_cfg[$past(ch_idx)] == ($past(bus_req.wdata) & AGICR_CH_WMASK)
  ) else $error("channel write lost");

  AST_CH_RESERVED_STORED: assert property ( // [RL14]
    1'b1
      |-> ch_cfg[ch_idx][11:10] == 2'b00
  ) else $error("reserved channel bits stored");

  AST_CH_EN_STABLE: assert property ( // [RL9]
    !wr_ch
      |=> $stable(ch_en)
  ) else $error("channel enables changed without a write");

  // pin side: drivers follow the register by one cycle, each synchroniser stage follows the one before by one cycle

  AST_PIN1_OE_FOLLOWS: assert property ( // [RL3]
    1'b1
      |=> pin_oe_n[1] == !$past(out_en[1])
  ) else $error("pin one drive enable does not follow");

  AST_PIN0_OE_FOLLOWS: assert property ( // [RL4]
    1'b1
      |=> pin_oe_n[0] == !$past(out_en[0])
  ) else $error("pin zero drive enable does not follow");

  AST_PIN_OUT_FOLLOWS: assert property ( // [RL5]
    1'b1
      |=> pin_out == $past(gp_val)
  ) else $error("pin drive value does not follow");

  AST_PIN_SYNC_CHAIN: assert property ( // [RL1]
    1'b1
      |=> pin_sync == $past(pin_meta)
  ) else $error("pin synchroniser skipped a stage");

  // sequencer: the channel moves only on advance, onto an enabled channel unless a channel write lands in the same cycle

  AST_SEQ_ACTIVE_LEVEL: assert property ( // [RL9]
    1'b1
      |=> seq_active == $past(|ch_en)
  ) else $error("sequencer activity flag wrong");

  AST_SEQ_STAYS: assert property ( // [RL9]
    !conv_done && ch_en[active_channel]
      |=> $stable(active_channel)
  ) else $error("sequencer moved without a finished conversion");

  AST_SEQ_SINGLE: assert property ( // [RL9]
    conv_done && (ch_en == (16'h0001 << active_channel))
      |=> $stable(active_channel)
  ) else $error("sequencer left the only enabled channel");

  AST_SEQ_IDLE: assert property ( // [RL9]
    ch_en == 16'h0000
      |=> $stable(active_channel) && !seq_active
  ) else $error("sequencer moved with no channel enabled");

  AST_SEQ_LEAVES_DISABLED: assert property ( // [RL9]
    !ch_en[active_channel] && (|ch_en)
      |=> active_channel != $past(active_channel)
  ) else $error("sequencer stayed on a disabled channel");

  AST_SEQ_TARGET_ENABLED: assert property ( // [RL9]
    seq_advance && (|ch_en) && !wr_ch
      |=> ch_en[active_channel]
  ) else $error("sequencer moved to a disabled channel");

  AST_SETUP_TRAILS: assert property ( // [RL11]
    1'b1
      |=> active_setup == $past(ch_cfg[active_channel][AGICR_SETUP_HI:AGICR_SETUP_LO])
  ) else $error("setup index does not trail the channel");

endmodule

`default_nettype wire

// [tb/agicr_far_model.sv]
// far-side model of the two general pins and whatever drives them externally
`timescale 1ns/10ps
`default_nettype none
module agicr_far_model (
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  input wire logic [1:0] ext_level,
  output logic [1:0] pin_in
);
  // a released pin shows the external level, never the stale device drive
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule
`default_nettype wire

// [tb/agicr_regs_tb.sv]
// self-checking bench for the pin, id and channel register bank
`timescale 1ns/10ps
`default_nettype none
module agicr_regs_tb;
  import agicr_pkg::*;
  // arbitrary product code, only needs to differ from the reset value of rdata
  localparam logic [15:0] TB_ID = 16'h3c5a;
  logic clk_sys;
  logic rst_n;
  agicr_bus_req_type req;
  logic [15:0] rdata;
  logic [15:0] val;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe_n;
  logic [1:0] ext_level;
  logic conv_done;
  logic seq_active;
  logic [3:0] active_channel;
  logic [2:0] active_setup;
  logic [9:0] active_input_code;
  int num_errors;
  int total_checks;
  agicr_regs #(.ID_CODE(TB_ID)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(req),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .conv_done(conv_done), .seq_active(seq_active), .active_channel(active_channel),
    .active_setup(active_setup), .active_input_code(active_input_code));
  agicr_far_model far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
    .pin_in(pin_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask
  // write then read the same address with no idle cycle between the strobes
  task automatic wr_rd(input string name, input logic [7:0] a, input logic [15:0] d,
                       input logic [15:0] exp);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    req <= '0;
    #1 check(name, exp, rdata);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    req <= '0;
    #1 check(name, exp, rdata);
  endtask
  // setup and input code lag the channel by one cycle, so look two edges on
  task automatic pulse_done();
    @(posedge clk_sys);
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic seq_chk(input logic [3:0] ch, input logic [2:0] su, input logic [9:0] code);
    #1 check("channel", {12'h000, ch}, {12'h000, active_channel});
    check("setup", {13'h0000, su}, {13'h0000, active_setup});
    check("input", {6'h00, code}, {6'h00, active_input_code});
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    $display("unexpected timeout");
    results();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    conv_done = 1'b0;
    ext_level = 2'b10;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 check("oe_n", 16'h0003, {14'h0000, pin_oe_n});
    rd_chk("pin cfg", AGICR_GPCFG_ADDR, 16'h0000);
    rd_chk("ch0", AGICR_CH_BASE, 16'h8001);
    for (int i = 1; i < 16; i++) begin
      rd_chk("chn", AGICR_CH_BASE + 8'(i), 16'h0001);
    end
    wr_rd("id", AGICR_ID_ADDR, 16'h0000, TB_ID);
    wr_rd("ch back", AGICR_CH_BASE + 8'h05, 16'h7fff, 16'h73ff);
    rd_chk("unmapped", 8'h08, 16'h0000);
    // every setup code appears twice, reserved bits always written high
    for (int i = 0; i < 16; i++) begin
      val = {1'b0, 3'(i), 12'hc00 | 12'(i)};
      wr(AGICR_CH_BASE + 8'(i), val);
      rd_chk("ch field", AGICR_CH_BASE + 8'(i), val & 16'hf3ff);
    end
    @(posedge clk_sys);
    #1 check("seq idle", 16'h0000, {15'h0000, seq_active});
    check("rdata idle", 16'h0000, rdata);
    wr(AGICR_CH_BASE + 8'h02, 16'hdd55);
    wr(AGICR_CH_BASE + 8'h09, 16'h96aa);
    repeat (2) @(posedge clk_sys);
    seq_chk(4'h2, 3'h5, 10'h155);
    check("seq on", 16'h0001, {15'h0000, seq_active});
    pulse_done();
    seq_chk(4'h9, 3'h1, 10'h2aa);
    pulse_done();
    seq_chk(4'h2, 3'h5, 10'h155);
    wr(AGICR_CH_BASE + 8'h09, 16'hd0aa);
    pulse_done();
    seq_chk(4'h9, 3'h5, 10'h0aa);
    wr(AGICR_GPCFG_ADDR, 16'h000e);
    repeat (2) @(posedge clk_sys);
    #1 check("pins out", 16'h0002, {12'h000, pin_oe_n, pin_out});
    rd_chk("pin rd", AGICR_GPCFG_ADDR, 16'h000e);
    wr(AGICR_GPCFG_ADDR, 16'h0031);
    repeat (4) @(posedge clk_sys);
    #1 check("pins in", 16'h000d, {12'h000, pin_oe_n, pin_out});
    rd_chk("pin in", AGICR_GPCFG_ADDR, 16'h0032);
    ext_level <= 2'b01;
    wr(AGICR_GPCFG_ADDR, 16'h0026);
    repeat (4) @(posedge clk_sys);
    #1 check("pins mix", 16'h000a, {12'h000, pin_oe_n, pin_out});
    rd_chk("pin mix", AGICR_GPCFG_ADDR, 16'h0024);
    results();
  end
endmodule
`default_nettype wire
